// *** design/analog_mux_hall_wake_ctrl.sv ***
// Analog select, current source, hall input and wake control logic
`include "analog_mux_hall_wake_consts.svh"
`default_nettype none
module analog_mux_hall_wake_ctrl
  import analog_mux_hall_wake_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  // Register port from the serial interface
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // System state and bits held elsewhere
  input  wire logic [1:0] power_mode_i,
  input  wire logic       power_stage_on_i,
  input  wire logic       hall_irq_mask_i,
  input  wire logic       hall_irq_clr_i,
  input  wire logic       wake_input_irq_enable_i,
  input  wire logic       pin_wake_clr_i,
  input  wire logic       bus_wake_clr_i,
  // Analog front-end status
  input  wire logic       hall_current_high_i,
  input  wire logic       hall_overcurrent_i,
  input  wire logic       hall_pin_level_i,
  input  wire logic       wake_pin_i,
  input  wire logic       bus_rx_i,
  // Multiplexer and current source controls
  output mux_route_type   mux_route_o,
  output logic      [3:0] mux_code_o,
  output logic            source_enable_o,
  output logic      [1:0] source_level_o,
  output logic            source_to_calib_o,
  output logic            sense_gain_low_o,
  // Hall pin controls
  output logic            hall_supply_on_o,
  output logic            hall_sense_en_o,
  output logic            hall_current_limit_o,
  output logic            hall_pullup_en_o,
  output logic            hall_level_flag_o,
  output logic            hall_irq_flag_o,
  output logic            hall_irq_o,
  // Wake pin and bus controls
  output logic            wake_input_level_o,
  output logic            wake_edge_irq_o,
  output logic            wake_up_o,
  output logic            pin_wake_flag_o,
  output logic            bus_wake_flag_o,
  output logic            bus_tx_enable_o,
  output logic            bus_pullup_on_o,
  output logic            bus_rx_enable_o
);

  // Decode a mux code into the routed source
  function automatic mux_route_type decode_route(input logic [3:0] code);
    mux_route_type r;
    r = ROUTE_NONE;
    if (code <= `MUX_HB_LAST) begin
      r = ROUTE_HB;
    end else if (code >= `MUX_HS_FIRST && code <= `MUX_HS_LAST) begin
      r = ROUTE_HS;
    end else if (code == `MUX_TEMP) begin
      r = ROUTE_TEMP;
    end else if (code == `MUX_VSUP) begin
      r = ROUTE_VSUP;
    end else if (code == `MUX_AUX) begin
      r = ROUTE_AUX;
    end else if (code == `MUX_CALIB) begin
      r = ROUTE_CALIB;
    end
    return r;
  endfunction

  logic [7:0]     asc_r;
  logic           hall_mode_r;
  logic           hall_sense_r;
  logic           hall_pullup_off_r;
  logic           hall_oc_r;
  logic           hall_level_r;
  logic           hall_level_nxt;
  logic           hall_prev_r;
  logic           hall_irq_r;
  logic           wake_level_r;
  logic           wake_latch_r;
  logic           pin_wake_r;
  logic           bus_wake_r;
  logic           bus_wake_pulse;
  logic           pin_wake_hit;
  lp_state_type   lp_state_r;
  mux_route_type  route;
  logic           in_run;
  logic           in_sleep;
  logic           low_power;
  logic           two_pin;
  logic           wr_hwc;
  logic           wr_asc;
  logic [7:0]     hwc_read;

  assign in_run    = (power_mode_i == MODE_RUN);
  assign in_sleep  = (power_mode_i == MODE_SLEEP);
  assign low_power = !in_run;
  assign two_pin   = hall_mode_r;
  assign wr_hwc    = reg_wr_i && (reg_addr_i == `ADDR_HALL_WAKE);
  assign wr_asc    = reg_wr_i && (reg_addr_i == `ADDR_ANALOG_SEL);
  assign route     = decode_route(asc_r[`ASC_MUX_HI:`ASC_MUX_LO]);

  // Analog select control register, all fields read/write
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      asc_r <= `ASC_RESET;
    end else if (wr_asc) begin
      asc_r <= reg_wdata_i;
    end
  end

  // Writable hall control bits, cleared by reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      hall_mode_r       <= 1'b0;
      hall_sense_r      <= 1'b0;
      hall_pullup_off_r <= 1'b0;
    end else if (wr_hwc) begin
      hall_mode_r       <= reg_wdata_i[`HWC_MODE_SEL];
      hall_sense_r      <= reg_wdata_i[`HWC_SENSE_ON];
      hall_pullup_off_r <= reg_wdata_i[`HWC_PULLUP_OFF];
    end
  end

  // Over-current flag: set in two-pin mode, write one clears, set wins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      hall_oc_r <= 1'b0;
    end else if (two_pin && hall_sense_r && hall_overcurrent_i) begin
      hall_oc_r <= 1'b1;
    end else if (wr_hwc && reg_wdata_i[`HWC_OC_FLAG]) begin
      hall_oc_r <= 1'b0;
    end
  end

  // Hall level: sensed current in two-pin mode, pin level otherwise
  always_comb begin
    if (two_pin) begin
      hall_level_nxt = hall_sense_r ? !hall_current_high_i : 1'b1;
    end else begin
      hall_level_nxt = hall_pin_level_i;
    end
  end

  // Hall level flag and its previous value for change detection
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      hall_level_r <= 1'b1;
      hall_prev_r  <= 1'b1;
    end else begin
      hall_level_r <= hall_level_nxt;
      hall_prev_r  <= hall_level_r;
    end
  end

  // Hall interrupt flag: any change in run mode sets it, set wins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      hall_irq_r <= 1'b0;
    end else if (in_run && (hall_level_r != hall_prev_r)) begin
      hall_irq_r <= 1'b1;
    end else if (hall_irq_clr_i) begin
      hall_irq_r <= 1'b0;
    end
  end

  // Wake pin level tracked in run mode, held in low power
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wake_level_r <= 1'b0;
    end else if (in_run) begin
      wake_level_r <= wake_pin_i;
    end
  end

  // Wake pin edge interrupt, both edges, passed only when enabled
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wake_edge_irq_o <= 1'b0;
    end else begin
      wake_edge_irq_o <= in_run && wake_input_irq_enable_i
                         && (wake_pin_i != wake_level_r);
    end
  end

  assign pin_wake_hit = (lp_state_r == LP_ARMED) && low_power
                        && (wake_pin_i != wake_latch_r);

  // Low-power tracker: latch wake level on entry, watch for change
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      lp_state_r   <= LP_RUN;
      wake_latch_r <= 1'b0;
    end else begin
      case (lp_state_r)
        LP_RUN: begin
          if (low_power) begin
            lp_state_r   <= LP_ARMED;
            wake_latch_r <= wake_pin_i;
          end
        end
        LP_ARMED: begin
          if (!low_power) begin
            lp_state_r <= LP_RUN;
          end else if (pin_wake_hit || bus_wake_pulse) begin
            lp_state_r <= LP_WOKEN;
          end
        end
        LP_WOKEN: begin
          if (!low_power) begin
            lp_state_r <= LP_RUN;
          end
        end
        default: begin
          lp_state_r <= LP_RUN;
        end
      endcase
    end
  end

  // Bus wake detection runs only while asleep
  bus_wake_filter u_bus_wake (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .enable_i  (in_sleep && (lp_state_r == LP_ARMED)),
    .bus_rx_i  (bus_rx_i),
    .wake_o    (bus_wake_pulse)
  );

  // Wake-up request pulse toward the reset logic
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wake_up_o <= 1'b0;
    end else begin
      wake_up_o <= pin_wake_hit || bus_wake_pulse;
    end
  end

  // Reset cause wake flags, write one clears, set wins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pin_wake_r <= 1'b0;
      bus_wake_r <= 1'b0;
    end else begin
      if (pin_wake_hit) begin
        pin_wake_r <= 1'b1;
      end else if (pin_wake_clr_i) begin
        pin_wake_r <= 1'b0;
      end
      if (bus_wake_pulse) begin
        bus_wake_r <= 1'b1;
      end else if (bus_wake_clr_i) begin
        bus_wake_r <= 1'b0;
      end
    end
  end

  // Multiplexer and current source drive, registered
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mux_route_o       <= ROUTE_NONE;
      mux_code_o        <= `MUX_HB_FIRST;
      source_enable_o   <= 1'b0;
      source_level_o    <= 2'b00;
      source_to_calib_o <= 1'b0;
      sense_gain_low_o  <= 1'b0;
    end else begin
      mux_route_o       <= route;
      mux_code_o        <= asc_r[`ASC_MUX_HI:`ASC_MUX_LO];
      source_enable_o   <= power_stage_on_i && asc_r[`ASC_SOURCE_ON]
                           && (route == ROUTE_AUX || route == ROUTE_CALIB)
                           && !low_power;
      source_level_o    <= asc_r[`ASC_LEVEL_HI:`ASC_LEVEL_LO];
      source_to_calib_o <= (route == ROUTE_CALIB);
      sense_gain_low_o  <= asc_r[`ASC_GAIN];
    end
  end

  // Hall pin drive, registered
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      hall_supply_on_o     <= 1'b0;
      hall_sense_en_o      <= 1'b0;
      hall_current_limit_o <= 1'b0;
      hall_pullup_en_o     <= 1'b1;
    end else begin
      hall_supply_on_o     <= two_pin && hall_sense_r;
      hall_sense_en_o      <= two_pin && hall_sense_r;
      hall_current_limit_o <= two_pin && hall_sense_r && hall_overcurrent_i;
      hall_pullup_en_o     <= !two_pin && !hall_pullup_off_r;
    end
  end

  // Bus transceiver control: transmitter and pull-up off in low power
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      bus_tx_enable_o <= 1'b0;
      bus_pullup_on_o <= 1'b1;
      bus_rx_enable_o <= 1'b1;
    end else begin
      bus_tx_enable_o <= power_stage_on_i && !low_power;
      bus_pullup_on_o <= !low_power;
      bus_rx_enable_o <= 1'b1;
    end
  end

  // Hall and wake control read image
  always_comb begin
    hwc_read = `RDATA_IDLE;
    hwc_read[`HWC_WAKE_LEVEL] = wake_level_r;
    hwc_read[`HWC_OC_FLAG]    = hall_oc_r;
    hwc_read[`HWC_HALL_LEVEL] = hall_level_r;
    hwc_read[`HWC_SENSE_ON]   = hall_sense_r;
    hwc_read[`HWC_PULLUP_OFF] = hall_pullup_off_r;
    hwc_read[`HWC_MODE_SEL]   = hall_mode_r;
  end

  // Registered read data, zero for unmapped addresses
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= `RDATA_IDLE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `ADDR_HALL_WAKE:  reg_rdata_o <= hwc_read;
        `ADDR_ANALOG_SEL: reg_rdata_o <= asc_r;
        default:          reg_rdata_o <= `RDATA_IDLE;
      endcase
    end
  end

  // Flag and status outputs
  assign hall_level_flag_o  = hall_level_r;
  assign hall_irq_flag_o    = hall_irq_r;
  assign hall_irq_o         = hall_irq_r && hall_irq_mask_i;
  assign wake_input_level_o = wake_level_r;
  assign pin_wake_flag_o    = pin_wake_r;
  assign bus_wake_flag_o    = bus_wake_r;

endmodule
`default_nettype wire

// *** design/analog_mux_hall_wake_consts.svh ***
// Constants for the analog select, hall input and wake control block
`ifndef ANALOG_MUX_HALL_WAKE_CONSTS_SVH
`define ANALOG_MUX_HALL_WAKE_CONSTS_SVH

// Register addresses and reset values
`define ADDR_HALL_WAKE      8'h07
`define ADDR_ANALOG_SEL     8'h08
`define ASC_RESET           8'h00
`define RDATA_IDLE          8'h00

// Analog select control fields
`define ASC_SOURCE_ON       7
`define ASC_LEVEL_HI        6
`define ASC_LEVEL_LO        5
`define ASC_GAIN            4
`define ASC_MUX_HI          3
`define ASC_MUX_LO          0

// Hall and wake control fields
`define HWC_WAKE_LEVEL      7
`define HWC_OC_FLAG         6
`define HWC_HALL_LEVEL      5
`define HWC_SENSE_ON        4
`define HWC_PULLUP_OFF      3
`define HWC_MODE_SEL        2
`define HWC_SPARE_HI        1
`define HWC_SPARE_LO        0

// Multiplexer source codes
`define MUX_HB_FIRST        4'h0
`define MUX_HB_LAST         4'h3
`define MUX_HS_FIRST        4'h4
`define MUX_HS_LAST         4'h6
`define MUX_TEMP            4'h8
`define MUX_VSUP            4'h9
`define MUX_AUX             4'hA
`define MUX_CALIB           4'hB

// Timing
`define CLK_FREQ_MHZ        20
`define BUS_WAKE_FILTER_US  100
`define BUS_WAKE_FILTER_CYC (`BUS_WAKE_FILTER_US * `CLK_FREQ_MHZ)
`define BUS_WAKE_CNT_W      12
`define HALL_SETTLE_US      40

`endif

// *** design/analog_mux_hall_wake_pkg.sv ***
// Types shared by the analog select, hall input and wake control block
`default_nettype none
package analog_mux_hall_wake_pkg;

  // Power mode reported by the system controller
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_STOP  = 2'b01,
    MODE_SLEEP = 2'b11
  } power_mode_type;

  // Source routed to the multiplexer output
  typedef enum logic [2:0] {
    ROUTE_NONE  = 3'h0,
    ROUTE_HB    = 3'h1,
    ROUTE_HS    = 3'h2,
    ROUTE_TEMP  = 3'h3,
    ROUTE_VSUP  = 3'h4,
    ROUTE_AUX   = 3'h5,
    ROUTE_CALIB = 3'h6
  } mux_route_type;

  // Low-power wake tracking, Gray coded along run, armed, woken
  typedef enum logic [1:0] {
    LP_RUN   = 2'b00,
    LP_ARMED = 2'b01,
    LP_WOKEN = 2'b11
  } lp_state_type;

endpackage
`default_nettype wire

// *** design/bus_wake_filter.sv ***
// Bus wake detector: long dominant level followed by a rising edge
`include "analog_mux_hall_wake_consts.svh"
`default_nettype none
module bus_wake_filter (
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  input  wire logic enable_i,
  input  wire logic bus_rx_i,
  output logic      wake_o
);

  logic [`BUS_WAKE_CNT_W-1:0] dom_cnt_r;
  logic                       rx_prev_r;
  logic                       long_dom;

  assign long_dom = (dom_cnt_r >= `BUS_WAKE_CNT_W'(`BUS_WAKE_FILTER_CYC));

  // Count dominant cycles, saturating once the filter time is reached
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      dom_cnt_r <= '0;
    end else if (!enable_i || bus_rx_i) begin
      dom_cnt_r <= '0;
    end else if (!long_dom) begin
      dom_cnt_r <= dom_cnt_r + `BUS_WAKE_CNT_W'(1);
    end
  end

  // Previous receiver level for edge detection
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= bus_rx_i;
    end
  end

  // Wake pulse on the rising edge that ends a long dominant phase
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= enable_i && long_dom && !rx_prev_r && bus_rx_i;
    end
  end

endmodule
`default_nettype wire

// *** bench/amhw_chk_asserts.sv ***
// Checker for the analog select, hall and wake control block
`default_nettype none
module amhw_chk_asserts (
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] power_mode_i,
  input wire logic       power_stage_on_i,
  input wire logic       wake_input_irq_enable_i,
  input wire logic [3:0] mux_code_o,
  input wire logic       source_enable_o,
  input wire logic       sense_gain_low_o,
  input wire logic       hall_irq_flag_o,
  input wire logic       wake_edge_irq_o,
  input wire logic       wake_up_o,
  input wire logic       bus_tx_enable_o,
  input wire logic       bus_rx_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Current source gating
  property p_src_lp;
    (power_mode_i != 2'b00) [*2] |-> !source_enable_o;
  endproperty
  a_src_lp: assert property (p_src_lp) else $error("source on in low power");
  property p_src_ps;
    (!power_stage_on_i) [*2] |-> !source_enable_o;
  endproperty
  a_src_ps: assert property (p_src_ps) else $error("source on without stage");
  property p_src_pin;
    source_enable_o |-> mux_code_o inside {4'hA, 4'hB};
  endproperty
  a_src_pin: assert property (p_src_pin) else $error("source on wrong code");
  // Bus in sleep
  property p_sleep_bus;
    (power_mode_i == 2'b11) [*2] |-> !bus_tx_enable_o && bus_rx_enable_o;
  endproperty
  a_sleep_bus: assert property (p_sleep_bus) else $error("bus state in sleep");
  // Register port
  property p_rd_back;
    reg_wr_i && reg_addr_i == 8'h08 ##1 reg_rd_i && !reg_wr_i && reg_addr_i == 8'h08
      |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("read back differs");
  property p_unmapped;
    reg_rd_i && reg_addr_i != 8'h07 && reg_addr_i != 8'h08 |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_gain;
    reg_wr_i && reg_addr_i == 8'h08 ##1 !(reg_wr_i && reg_addr_i == 8'h08)
      |=> sense_gain_low_o == $past(reg_wdata_i[4], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("gain select wrong");
  // Interrupt and wake timing
  property p_hall_run;
    $rose(hall_irq_flag_o) |-> $past(power_mode_i) == 2'b00 || $past(power_mode_i, 2) == 2'b00;
  endproperty
  a_hall_run: assert property (p_hall_run) else $error("hall flag outside run");
  property p_wake_irq;
    wake_edge_irq_o |-> $past(wake_input_irq_enable_i) && $past(power_mode_i) == 2'b00
      ##1 !wake_edge_irq_o;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake edge irq wrong");
  property p_wake_pulse;
    wake_up_o |-> $past(power_mode_i) != 2'b00 ##1 !wake_up_o;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse wrong");
  c_src: cover property (source_enable_o);
  c_hall: cover property ($rose(hall_irq_flag_o));
  c_wake: cover property (wake_up_o);
endmodule
bind analog_mux_hall_wake_ctrl amhw_chk_asserts u_amhw_chk_asserts (
  .sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .power_mode_i, .power_stage_on_i, .wake_input_irq_enable_i, .mux_code_o,
  .source_enable_o, .sense_gain_low_o, .hall_irq_flag_o, .wake_edge_irq_o, .wake_up_o,
  .bus_tx_enable_o, .bus_rx_enable_o
);
`default_nettype wire

// *** bench/mcu_side_model.sv ***
// Microcontroller side: interrupt capture and hall settle timer
`default_nettype none
module mcu_side_model #(
  parameter int SETTLE_CYC = 800
) (
  input  wire logic       sys_clk_i,
  input  wire logic       hall_irq_i,
  input  wire logic       wake_irq_i,
  input  wire logic       sense_start_i,
  output logic      [7:0] hall_irq_cnt_o,
  output logic      [7:0] wake_irq_cnt_o,
  output logic            settled_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] settle_cnt = 16'h0000;
  logic        hall_prev  = 1'b0;
  initial hall_irq_cnt_o = 8'h00;
  initial wake_irq_cnt_o = 8'h00;
  // Count interrupt requests as the core would take them
  always @(posedge sys_clk_i) begin
    hall_prev <= hall_irq_i;
    if (hall_irq_i && !hall_prev) hall_irq_cnt_o <= hall_irq_cnt_o + 8'h01;
    if (wake_irq_i) wake_irq_cnt_o <= wake_irq_cnt_o + 8'h01;
  end
  // Settle timer restarted when software switches the sensor on
  always @(posedge sys_clk_i) begin
    if (sense_start_i) settle_cnt <= 16'h0000;
    else if (settle_cnt != 16'hFFFF) settle_cnt <= settle_cnt + 16'h0001;
  end
  assign settled_o = (settle_cnt >= SETTLE_CYC);
endmodule
`default_nettype wire

// *** bench/analog_mux_hall_wake_ctrl_tb_top.sv ***
// Self-checking testbench for the analog select, hall and wake control block
`include "analog_mux_hall_wake_consts.svh"
`default_nettype none
module analog_mux_hall_wake_ctrl_tb_top
  import analog_mux_hall_wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          sys_clk_i = 1'b0, rst_b_i, reg_wr_i, reg_rd_i, power_stage_on_i;
  logic    [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d, hall_cnt, wake_cnt;
  logic    [1:0] power_mode_i, source_level_o;
  logic    [3:0] mux_code_o;
  logic          hall_irq_mask_i, hall_irq_clr_i, wake_input_irq_enable_i, pin_wake_clr_i;
  logic          bus_wake_clr_i, hall_current_high_i, hall_overcurrent_i, hall_pin_level_i;
  logic          wake_pin_i, bus_rx_i, sense_start, settled, source_enable_o;
  logic          source_to_calib_o, sense_gain_low_o, hall_supply_on_o, hall_sense_en_o;
  logic          hall_current_limit_o, hall_pullup_en_o, hall_level_flag_o, hall_irq_flag_o;
  logic          hall_irq_o, wake_input_level_o, wake_edge_irq_o, wake_up_o, pin_wake_flag_o;
  logic          bus_wake_flag_o, bus_tx_enable_o, bus_pullup_on_o, bus_rx_enable_o;
  mux_route_type mux_route_o;
  int            bad_count = 0, tests_run = 0;
  typedef struct {logic [7:0] asc; logic ps; logic [1:0] md; logic en; mux_route_type rt;}
    row_type;
  row_type rows [14] = '{
    '{8'h8A, 1'b1, 2'b00, 1'b1, ROUTE_AUX}, '{8'hBB, 1'b1, 2'b00, 1'b1, ROUTE_CALIB},
    '{8'hCA, 1'b1, 2'b00, 1'b1, ROUTE_AUX}, '{8'hEB, 1'b1, 2'b00, 1'b1, ROUTE_CALIB},
    '{8'hEA, 1'b0, 2'b00, 1'b0, ROUTE_AUX}, '{8'h6A, 1'b1, 2'b00, 1'b0, ROUTE_AUX},
    '{8'hE8, 1'b1, 2'b00, 1'b0, ROUTE_TEMP}, '{8'hF9, 1'b1, 2'b00, 1'b0, ROUTE_VSUP},
    '{8'h93, 1'b1, 2'b00, 1'b0, ROUTE_HB}, '{8'hD6, 1'b1, 2'b00, 1'b0, ROUTE_HS},
    '{8'hE7, 1'b1, 2'b00, 1'b0, ROUTE_NONE}, '{8'hEF, 1'b1, 2'b00, 1'b0, ROUTE_NONE},
    '{8'hEA, 1'b1, 2'b01, 1'b0, ROUTE_AUX}, '{8'hEA, 1'b1, 2'b11, 1'b0, ROUTE_AUX}};
  analog_mux_hall_wake_ctrl u_analog_mux_hall_wake_ctrl (
    .sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .power_mode_i, .power_stage_on_i, .hall_irq_mask_i, .hall_irq_clr_i,
    .wake_input_irq_enable_i, .pin_wake_clr_i, .bus_wake_clr_i, .hall_current_high_i,
    .hall_overcurrent_i, .hall_pin_level_i, .wake_pin_i, .bus_rx_i, .mux_route_o,
    .mux_code_o, .source_enable_o, .source_level_o, .source_to_calib_o, .sense_gain_low_o,
    .hall_supply_on_o, .hall_sense_en_o, .hall_current_limit_o, .hall_pullup_en_o,
    .hall_level_flag_o, .hall_irq_flag_o, .hall_irq_o, .wake_input_level_o,
    .wake_edge_irq_o, .wake_up_o, .pin_wake_flag_o, .bus_wake_flag_o, .bus_tx_enable_o,
    .bus_pullup_on_o, .bus_rx_enable_o);
  mcu_side_model #(.SETTLE_CYC(`HALL_SETTLE_US * `CLK_FREQ_MHZ)) u_mcu_side_model (
    .sys_clk_i, .hall_irq_i(hall_irq_o), .wake_irq_i(wake_edge_irq_o),
    .sense_start_i(sense_start), .hall_irq_cnt_o(hall_cnt), .wake_irq_cnt_o(wake_cnt),
    .settled_o(settled));
  // 20 MHz clock
  always #25 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cyc(1);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    cyc(1);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  task automatic wait_wake();
    for (int k = 0; k < 8 && wake_up_o !== 1'b1; k++) cyc(1);
    chk(wake_up_o, 1'b1);
    cyc(1);
    chk(wake_up_o, 1'b0);
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog against a hung sequence
  initial begin
    #1_000_000;
    bad_count++;
    summarize();
  end
  initial begin
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, power_mode_i} = '0;
    {power_stage_on_i, hall_irq_mask_i, hall_irq_clr_i, wake_input_irq_enable_i} = '0;
    {pin_wake_clr_i, bus_wake_clr_i, hall_current_high_i, hall_overcurrent_i} = '0;
    {wake_pin_i, sense_start} = '0;
    {hall_pin_level_i, bus_rx_i} = 2'b11;
    rst_b_i = 1'b0;
    cyc(20);
    rst_b_i = 1'b1;
    rd(8'h08);
    chk(d, 8'h00);
    rd(8'h07);
    chk(d, 8'h20);
    chk(hall_pullup_en_o, 1'b1);
    wr(8'h10, 8'hFF);
    rd(8'h10);
    chk(d, 8'h00);
    // Back-to-back write then read of the analog select register
    cyc(1);
    {reg_addr_i, reg_wdata_i, reg_wr_i} = {8'h08, 8'h5A, 1'b1};
    cyc(1);
    {reg_wr_i, reg_rd_i} = 2'b01;
    cyc(1);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, 8'h5A);
    $display("Reset test done");
    foreach (rows[i]) begin
      power_stage_on_i = rows[i].ps;
      power_mode_i = rows[i].md;
      wr(8'h08, rows[i].asc);
      cyc(3);
      chk(source_enable_o, rows[i].en);
      chk(mux_route_o, rows[i].rt);
      chk(source_to_calib_o, rows[i].rt == ROUTE_CALIB);
      chk(mux_code_o, rows[i].asc[3:0]);
      chk(source_level_o, rows[i].asc[6:5]);
      chk(sense_gain_low_o, rows[i].asc[4]);
      rd(8'h08);
      chk(d, rows[i].asc);
    end
    power_mode_i = 2'b00;
    $display("Table test done");
    // General purpose hall input, pull-up and edge flag
    wr(8'h07, 8'h08);
    cyc(3);
    chk(hall_pullup_en_o, 1'b0);
    wr(8'h07, 8'h00);
    hall_irq_mask_i = 1'b1;
    hall_pin_level_i = 1'b0;
    cyc(3);
    chk(hall_level_flag_o, 1'b0);
    chk(hall_irq_o, 1'b1);
    chk(hall_cnt, 8'h01);
    hall_irq_clr_i = 1'b1;
    cyc(1);
    hall_irq_clr_i = 1'b0;
    hall_irq_mask_i = 1'b0;
    hall_pin_level_i = 1'b1;
    cyc(3);
    chk({hall_irq_flag_o, hall_irq_o}, 2'b10);
    hall_irq_clr_i = 1'b1;
    cyc(1);
    hall_irq_clr_i = 1'b0;
    power_mode_i = 2'b01;
    cyc(2);
    hall_pin_level_i = 1'b0;
    cyc(3);
    chk(hall_irq_flag_o, 1'b0);
    power_mode_i = 2'b00;
    $display("Hall input test done");
    // Two-pin sensor with settle wait and over-current
    wr(8'h07, 8'h14);
    sense_start = 1'b1;
    cyc(1);
    sense_start = 1'b0;
    for (int k = 0; k < 1000 && !settled; k++) cyc(1);
    chk({hall_supply_on_o, hall_sense_en_o, hall_level_flag_o}, 3'b111);
    hall_irq_clr_i = 1'b1;
    cyc(1);
    hall_irq_clr_i = 1'b0;
    hall_current_high_i = 1'b1;
    cyc(3);
    chk({hall_level_flag_o, hall_irq_flag_o}, 2'b01);
    hall_overcurrent_i = 1'b1;
    cyc(3);
    chk(hall_current_limit_o, 1'b1);
    hall_overcurrent_i = 1'b0;
    rd(8'h07);
    chk(d[6], 1'b1);
    wr(8'h07, 8'h14);
    rd(8'h07);
    chk(d[6], 1'b1);
    wr(8'h07, 8'h54);
    rd(8'h07);
    chk(d[6], 1'b0);
    wr(8'h07, 8'h00);
    $display("Two-pin test done");
    // Wake pin edges in run
    wake_input_irq_enable_i = 1'b1;
    repeat (2) begin
      wake_pin_i = !wake_pin_i;
      cyc(1);
      chk(wake_edge_irq_o, 1'b1);
      cyc(1);
      chk(wake_input_level_o, wake_pin_i);
    end
    wake_input_irq_enable_i = 1'b0;
    wake_pin_i = 1'b1;
    cyc(2);
    chk(wake_cnt, 8'h02);
    // Pin wake from stop
    power_mode_i = 2'b01;
    cyc(3);
    wake_pin_i = 1'b0;
    wait_wake();
    chk(pin_wake_flag_o, 1'b1);
    pin_wake_clr_i = 1'b1;
    cyc(1);
    pin_wake_clr_i = 1'b0;
    cyc(1);
    chk(pin_wake_flag_o, 1'b0);
    power_mode_i = 2'b00;
    cyc(2);
    $display("Wake pin test done");
    // Bus wake from sleep, short then long dominant
    power_mode_i = 2'b11;
    cyc(3);
    chk({bus_tx_enable_o, bus_pullup_on_o, bus_rx_enable_o}, 3'b001);
    bus_rx_i = 1'b0;
    cyc(100);
    bus_rx_i = 1'b1;
    cyc(5);
    chk(bus_wake_flag_o, 1'b0);
    bus_rx_i = 1'b0;
    cyc(`BUS_WAKE_FILTER_CYC + 100);
    bus_rx_i = 1'b1;
    wait_wake();
    chk(bus_wake_flag_o, 1'b1);
    bus_wake_clr_i = 1'b1;
    cyc(1);
    bus_wake_clr_i = 1'b0;
    cyc(1);
    chk(bus_wake_flag_o, 1'b0);
    // Back in run the transmitter and pull-up return
    power_mode_i = 2'b00;
    cyc(3);
    chk({bus_tx_enable_o, bus_pullup_on_o, bus_rx_enable_o}, 3'b111);
    $display("Bus wake test done");
    summarize();
  end
endmodule
`default_nettype wire
